// file: logic/sfcaf_consts.vh
// constants of the serial flash command and address front end
// assumes byte addresses on the avalon slave, one 32-bit word per register
`ifndef SFCAF_CONSTS_VH
`define SFCAF_CONSTS_VH

// register byte offsets
`define SFCAF_REG_CONFIG    5'h00
`define SFCAF_REG_UAE       5'h04
`define SFCAF_REG_BUSY      5'h08
`define SFCAF_REG_EVENTS    5'h0C
`define SFCAF_REG_LASTCMD   5'h10
`define SFCAF_REG_ADDR      5'h14
`define SFCAF_REG_RDATA     5'h18

// field positions
`define SFCAF_CFG_WIDE      0
`define SFCAF_CFG_QUAD      1
`define SFCAF_CFG_ACTIVE    2
`define SFCAF_EV_REJECT     0
`define SFCAF_EV_IGNORE     1
`define SFCAF_EV_EXEC       2

// reset values
`define SFCAF_UAE_RST       1'b0
`define SFCAF_RDATA_RST     8'hFF

// opcodes
`define SFCAF_OP_READ       8'h03
`define SFCAF_OP_FAST       8'h0B
`define SFCAF_OP_PP         8'h02
`define SFCAF_OP_SE         8'h20
`define SFCAF_OP_BE32K      8'h52
`define SFCAF_OP_BE         8'hD8
`define SFCAF_OP_CE1        8'h60
`define SFCAF_OP_CE2        8'hC7
`define SFCAF_OP_READ4B     8'h13
`define SFCAF_OP_FAST4B     8'h0C
`define SFCAF_OP_PP4B       8'h12
`define SFCAF_OP_SE4B       8'h21
`define SFCAF_OP_BE32K4B    8'h5C
`define SFCAF_OP_BE4B       8'hDC
`define SFCAF_OP_WREN       8'h06
`define SFCAF_OP_WRDI       8'h04
`define SFCAF_OP_RDSR       8'h05
`define SFCAF_OP_ENWIDE     8'hB7
`define SFCAF_OP_EXWIDE     8'hE9
`define SFCAF_OP_WRUAE      8'hC5
`define SFCAF_OP_RDUAE      8'hC8
`define SFCAF_OP_QENTER     8'h35
`define SFCAF_OP_QEXIT      8'hF5

// timing
`define SFCAF_DUMMY_CYC     8

`endif

// file: logic/sfcaf_sync.v
// two flip-flop synchroniser for a bundle of pin inputs
// assumes each bit is an independent level from outside the clock domain
`default_nettype none

module sfcaf_sync #(
  parameter WIDTH = 6,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_i,   // system clock
  input  wire             rstn_i,  // async reset, active low
  input  wire [WIDTH-1:0] async_i, // raw pin levels
  output reg  [WIDTH-1:0] sync_o   // synchronised levels
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // sfcaf_sync

`default_nettype wire

// file: logic/sfcaf_frontend.v
// serial flash command framing and address-width front end with avalon-mm registers
// assumes serial clock far slower than clk_i (at least 4 clk_i periods per half cycle)
//
// Functional notes
// - unknown opcode: go standby, output floats, until next chip select fall
// - valid opcode: stay active until the next chip select rise; an array opcode while busy goes standby instead
// - sample on serial clock rise, shift out on fall; modes 0 and 3
// - write-type frames must end on a byte boundary or are rejected
// - array access ignored while a write or erase is busy
// - enter-wide-address sets wide flag; address phase becomes 32 bits
// - wide mode on by enter command, off by exit command
// - in wide mode the extension bit 0 is ignored
// - dedicated wide opcodes always take a 32-bit address
// - 8-bit volatile extension register supplies A31 to A24 for 3-byte addresses; this design keeps only bit 0, which supplies A24
// - extension bits 7 to 1 read zero; bit 0 resets to zero
// - 3-byte read, program, erase act inside the selected segment
// - continuous read crosses into the other segment, extension unchanged
// - a new start address falls inside the selected segment
// - chip erase covers the whole array, ignoring the segment
// - quad protocol carries opcode, address and data on four lines
// - quad enter opcode switches on the quad protocol
// - quad exit opcode returns to single-line transfer
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`default_nettype none
`include "sfcaf_consts.vh"

module sfcaf_frontend #(
  parameter DUMMY_CYC = `SFCAF_DUMMY_CYC,
  parameter AW        = 25
) (
  input  wire        clk_i,             // system clock, 10 MHz
  input  wire        rstn_i,            // async reset, active low
  input  wire        cs_n_i,            // chip select pin, active low
  input  wire        sclk_i,            // serial clock pin
  input  wire [3:0]  io_i,              // data pins in, io0 is serial in
  output reg  [3:0]  io_o,              // data pins out, io1 is serial out
  output wire [3:0]  io_oe_o,           // data pin drive enables
  input  wire [4:0]  avs_address_i,     // avalon byte address
  input  wire        avs_read_i,        // avalon read
  input  wire        avs_write_i,       // avalon write
  input  wire [31:0] avs_writedata_i,   // avalon write data
  input  wire [3:0]  avs_byteenable_i,  // avalon byte enables
  output reg  [31:0] avs_readdata_o,    // avalon read data
  output wire        avs_waitrequest_o, // avalon wait request
  output reg         exec_valid_o,      // one-cycle array operation pulse
  output reg  [7:0]  exec_op_o,         // opcode of the operation
  output reg  [AW-1:0] exec_addr_o      // effective array address
);

  localparam [2:0] C_NONE = 3'h0, C_READ = 3'h1, C_FAST = 3'h2, C_PROG = 3'h3;
  localparam [2:0] C_ERASE = 3'h4, C_CHIP = 3'h5, C_MODE = 3'h6, C_REG = 3'h7;

  localparam [2:0] ST_STBY = 3'h0, ST_OPC = 3'h1, ST_ADDR = 3'h2, ST_DUMMY = 3'h3;
  localparam [2:0] ST_DOUT = 3'h4, ST_DIN = 3'h5, ST_HOLD = 3'h6;

  function [2:0] op_class;
    input [7:0] op;
    begin
      case (op)
        `SFCAF_OP_READ, `SFCAF_OP_READ4B:                 op_class = C_READ;
        `SFCAF_OP_FAST, `SFCAF_OP_FAST4B:                 op_class = C_FAST;
        `SFCAF_OP_PP, `SFCAF_OP_PP4B:                     op_class = C_PROG;
        `SFCAF_OP_SE, `SFCAF_OP_SE4B, `SFCAF_OP_BE32K,
        `SFCAF_OP_BE32K4B, `SFCAF_OP_BE, `SFCAF_OP_BE4B:  op_class = C_ERASE;
        `SFCAF_OP_CE1, `SFCAF_OP_CE2:                     op_class = C_CHIP;
        `SFCAF_OP_WREN, `SFCAF_OP_WRDI, `SFCAF_OP_ENWIDE,
        `SFCAF_OP_EXWIDE, `SFCAF_OP_QENTER,
        `SFCAF_OP_QEXIT:                                  op_class = C_MODE;
        `SFCAF_OP_RDSR, `SFCAF_OP_RDUAE,
        `SFCAF_OP_WRUAE:                                  op_class = C_REG;
        default:                                          op_class = C_NONE;
      endcase
    end
  endfunction

  // dedicated wide opcodes
  function is_wide_op;
    input [7:0] op;
    begin
      is_wide_op = (op == `SFCAF_OP_READ4B) || (op == `SFCAF_OP_FAST4B) || (op == `SFCAF_OP_PP4B) ||
                   (op == `SFCAF_OP_SE4B) || (op == `SFCAF_OP_BE32K4B) || (op == `SFCAF_OP_BE4B);
    end
  endfunction

  // effective address: segment bit from extension unless the address is full width
  function [AW-1:0] eff_addr;
    input [31:0] a;
    input        wide;
    input        seg;
    begin
      if (wide)
        eff_addr = a[AW-1:0];
      else
        eff_addr = {seg, a[AW-2:0]};
    end
  endfunction

  // pin synchronisation and edge detection
  wire [5:0] pins_s;
  reg        sclk_q;
  reg        cs_q;

  sfcaf_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h20)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i ({cs_n_i, sclk_i, io_i}),
    .sync_o  (pins_s)
  );

  wire       cs_s      = pins_s[5];
  wire       sclk_s    = pins_s[4];
  wire [3:0] io_s      = pins_s[3:0];
  wire       sclk_rise = sclk_s & ~sclk_q;
  wire       sclk_fall = ~sclk_s & sclk_q;
  wire       cs_fall   = ~cs_s & cs_q;
  wire       cs_rise   = cs_s & ~cs_q;

  // device state
  reg [2:0]    state;
  reg [2:0]    cls;
  reg [7:0]    opcode;
  reg [31:0]   addr_sh;
  reg [5:0]    cnt;
  reg [5:0]    addr_bits;
  reg [2:0]    bitmod;
  reg [7:0]    din;
  reg [7:0]    dout_sh;
  reg          dout_on;
  reg [AW-1:0] cur_addr;
  reg          wide_address_flag;
  reg          quad_command_protocol;
  reg          upper_address_extension;
  reg          busy;
  reg [7:0]    rdata;
  reg [2:0]    events;
  reg [7:0]    last_cmd;
  reg          ev_rej;
  reg          ev_ign;

  wire [5:0] step     = quad_command_protocol ? 6'd4 : 6'd1;
  wire [7:0] shin     = quad_command_protocol ? {addr_sh[3:0], io_s} : {addr_sh[6:0], io_s[0]};
  wire [7:0] din_in   = quad_command_protocol ? {din[3:0], io_s} : {din[6:0], io_s[0]};
  wire [2:0] ncls     = op_class(shin);
  wire       array_op = (ncls == C_READ) || (ncls == C_FAST) || (ncls == C_PROG) ||
                        (ncls == C_ERASE) || (ncls == C_CHIP);
  wire       wtype    = (cls == C_PROG) || (cls == C_ERASE) || (cls == C_CHIP) || (cls == C_MODE) ||
                        (cls == C_REG && opcode == `SFCAF_OP_WRUAE);
  wire       complete = (state == ST_HOLD) || (state == ST_DIN && cls == C_PROG);
  wire [31:0] a_next  = quad_command_protocol ? {addr_sh[27:0], io_s} : {addr_sh[30:0], io_s[0]};
  wire [7:0] reg_byte = (opcode == `SFCAF_OP_RDSR) ? {6'h00, wide_address_flag, busy} :
                        {7'h00, upper_address_extension};

  assign io_oe_o = !dout_on ? 4'h0 : (quad_command_protocol ? 4'hF : 4'h2);

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_q   <= cs_s;
    end
  end

  // avalon slave: one wait state, answer on the second edge
  reg  ack;
  wire req = avs_read_i | avs_write_i;
  wire wr  = avs_write_i & ack & avs_byteenable_i[0];
  assign avs_waitrequest_o = req & ~ack;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack <= req & ~ack;
      if (avs_read_i && !ack)
      begin
        if (avs_address_i == `SFCAF_REG_CONFIG)
          avs_readdata_o <= {29'h0, (state != ST_STBY), quad_command_protocol, wide_address_flag};
        else if (avs_address_i == `SFCAF_REG_UAE)
          avs_readdata_o <= {31'h0, upper_address_extension};
        else if (avs_address_i == `SFCAF_REG_BUSY)
          avs_readdata_o <= {31'h0, busy};
        else if (avs_address_i == `SFCAF_REG_EVENTS)
          avs_readdata_o <= {29'h0, events};
        else if (avs_address_i == `SFCAF_REG_LASTCMD)
          avs_readdata_o <= {24'h0, last_cmd};
        else if (avs_address_i == `SFCAF_REG_ADDR)
          avs_readdata_o <= {{(32-AW){1'b0}}, cur_addr};
        else if (avs_address_i == `SFCAF_REG_RDATA)
          avs_readdata_o <= {24'h0, rdata};
        else
          avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // software registers; sticky events: set wins over write-one-clear
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy   <= 1'b0;
      rdata  <= `SFCAF_RDATA_RST;
      events <= 3'h0;
    end
    else
    begin
      if (wr && avs_address_i == `SFCAF_REG_BUSY)
        busy <= avs_writedata_i[0];
      if (wr && avs_address_i == `SFCAF_REG_RDATA)
        rdata <= avs_writedata_i[7:0];
      events <= (events & ~((wr && avs_address_i == `SFCAF_REG_EVENTS) ? avs_writedata_i[2:0] : 3'h0)) |
                {exec_valid_o, ev_ign, ev_rej};
    end
  end

  // serial frame engine
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state                   <= ST_STBY;
      cls                     <= C_NONE;
      opcode                  <= 8'h00;
      addr_sh                 <= 32'h0000_0000;
      cnt                     <= 6'd0;
      addr_bits               <= 6'd24;
      bitmod                  <= 3'd0;
      din                     <= 8'h00;
      dout_sh                 <= 8'h00;
      dout_on                 <= 1'b0;
      io_o                    <= 4'h0;
      cur_addr                <= {AW{1'b0}};
      wide_address_flag       <= 1'b0;
      quad_command_protocol   <= 1'b0;
      upper_address_extension <= `SFCAF_UAE_RST;
      last_cmd                <= 8'h00;
      ev_rej                  <= 1'b0;
      ev_ign                  <= 1'b0;
      exec_valid_o            <= 1'b0;
      exec_op_o               <= 8'h00;
      exec_addr_o             <= {AW{1'b0}};
    end
    else
    begin
      ev_rej       <= 1'b0;
      ev_ign       <= 1'b0;
      exec_valid_o <= 1'b0;
      if (wr && avs_address_i == `SFCAF_REG_UAE)
        upper_address_extension <= avs_writedata_i[0];
      if (cs_rise)
      begin
        state   <= ST_STBY;
        dout_on <= 1'b0;
        if (state != ST_STBY && wtype)
        begin
          if (complete && bitmod == 3'd0)
          begin
            last_cmd <= opcode;
            case (opcode)
              `SFCAF_OP_ENWIDE: wide_address_flag       <= 1'b1;
              `SFCAF_OP_EXWIDE: wide_address_flag       <= 1'b0;
              `SFCAF_OP_QENTER: quad_command_protocol   <= 1'b1;
              `SFCAF_OP_QEXIT:  quad_command_protocol   <= 1'b0;
              `SFCAF_OP_WRUAE:  upper_address_extension <= din[0];
              default:          quad_command_protocol   <= quad_command_protocol;
            endcase
            if (cls == C_PROG || cls == C_ERASE || cls == C_CHIP)
            begin
              exec_valid_o <= 1'b1;
              exec_op_o    <= opcode;
              exec_addr_o  <= (cls == C_CHIP) ? {AW{1'b0}} : cur_addr;
            end
          end
          else
            ev_rej <= 1'b1;
        end
      end
      else if (cs_fall)
      begin
        state   <= ST_OPC;
        cnt     <= 6'd0;
        bitmod  <= 3'd0;
        dout_on <= 1'b0;
      end
      else if (sclk_rise && state != ST_STBY && state != ST_DOUT)
      begin
        bitmod <= bitmod + step[2:0];
        case (state)
          ST_OPC:
          begin
            addr_sh <= {24'h0, shin};
            if (cnt + step == 6'd8)
            begin
              cnt    <= 6'd0;
              opcode <= shin;
              cls    <= ncls;
              if (ncls == C_NONE)
                state <= ST_STBY;
              else if (array_op && busy)
              begin
                state  <= ST_STBY;
                ev_ign <= 1'b1;
              end
              else if (ncls == C_READ || ncls == C_FAST || ncls == C_PROG || ncls == C_ERASE)
              begin
                state     <= ST_ADDR;
                addr_bits <= (wide_address_flag || is_wide_op(shin)) ? 6'd32 : 6'd24;
              end
              else if (ncls == C_REG && shin != `SFCAF_OP_WRUAE)
              begin
                state   <= ST_DOUT;
                dout_sh <= (shin == `SFCAF_OP_RDSR) ? {6'h00, wide_address_flag, busy} :
                           {7'h00, upper_address_extension};
              end
              else if (ncls == C_REG)
                state <= ST_DIN;
              else
                state <= ST_HOLD;
            end
            else
              cnt <= cnt + step;
          end
          ST_ADDR:
          begin
            addr_sh <= a_next;
            if (cnt + step == addr_bits)
            begin
              cnt      <= 6'd0;
              cur_addr <= eff_addr(a_next, addr_bits == 6'd32, upper_address_extension);
              if (cls == C_READ)
              begin
                state   <= ST_DOUT;
                dout_sh <= rdata;
              end
              else if (cls == C_FAST)
                state <= ST_DUMMY;
              else if (cls == C_PROG)
                state <= ST_DIN;
              else
                state <= ST_HOLD;
            end
            else
              cnt <= cnt + step;
          end
          ST_DUMMY:
          begin
            if (cnt + 6'd1 == DUMMY_CYC[5:0])
            begin
              cnt     <= 6'd0;
              state   <= ST_DOUT;
              dout_sh <= rdata;
            end
            else
              cnt <= cnt + 6'd1;
          end
          ST_DIN:
          begin
            din <= din_in;
            if (cnt + step == 6'd8)
            begin
              cnt <= 6'd0;
              if (cls == C_REG)
                state <= ST_HOLD;
            end
            else
              cnt <= cnt + step;
          end
          default:
            cnt <= cnt;
        endcase
      end
      else if (sclk_fall && state == ST_DOUT)
      begin
        dout_on <= 1'b1;
        if (quad_command_protocol)
        begin
          io_o    <= dout_sh[7:4];
          dout_sh <= {dout_sh[3:0], 4'h0};
        end
        else
        begin
          io_o    <= {2'b00, dout_sh[7], 1'b0};
          dout_sh <= {dout_sh[6:0], 1'b0};
        end
        if (cnt + step == 6'd8)
        begin
          cnt     <= 6'd0;
          dout_sh <= (cls == C_REG) ? reg_byte : rdata;
          if (cls != C_REG)
            cur_addr <= cur_addr + {{(AW-1){1'b0}}, 1'b1};
        end
        else
          cnt <= cnt + step;
      end
    end
  end

endmodule // sfcaf_frontend

`default_nettype wire

// file: tb/sfcaf_frontend_sva.sv
// checker for the serial flash front end: pin, avalon and operation-pulse timing
// assumes it is bound into sfcaf_frontend and sees only that module's ports
`default_nettype none
`include "sfcaf_consts.vh"

module sfcaf_frontend_sva #(
  parameter int AW = 25
) (
  input wire logic          clk_i,             // system clock
  input wire logic          rstn_i,            // async reset, active low
  input wire logic          cs_n_i,            // chip select pin
  input wire logic          sclk_i,            // serial clock pin
  input wire logic [3:0]    io_o,              // data pins out
  input wire logic [3:0]    io_oe_o,           // data pin enables
  input wire logic [4:0]    avs_address_i,     // avalon address
  input wire logic          avs_read_i,        // avalon read
  input wire logic          avs_write_i,       // avalon write
  input wire logic [31:0]   avs_readdata_o,    // avalon read data
  input wire logic          avs_waitrequest_o, // avalon wait
  input wire logic          exec_valid_o,      // operation pulse
  input wire logic [7:0]    exec_op_o,         // operation opcode
  input wire logic [AW-1:0] exec_addr_o        // operation address
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_oe_legal: assert property (io_oe_o inside {4'h0, 4'h2, 4'hF})
    else $error("drive enable pattern not allowed");
  a_oe_idle: assert property (cs_n_i [*5] |-> io_oe_o == 4'h0)
    else $error("data pins driven while deselected");
  a_out_hold: assert property ((io_oe_o != 4'h0) && $rose(sclk_i) |=> $stable(io_o) [*3])
    else $error("output changed after a serial clock rise");
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  a_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait asserted without a request");
  a_exec_pulse: assert property (exec_valid_o |=> !exec_valid_o)
    else $error("operation pulse longer than one cycle");
  a_exec_frame: assert property (exec_valid_o |-> cs_n_i && $past(cs_n_i, 2))
    else $error("operation issued before the frame ended");
  a_ce_whole: assert property (exec_valid_o && (exec_op_o inside {`SFCAF_OP_CE1, `SFCAF_OP_CE2})
    |-> exec_addr_o == '0)
    else $error("chip erase carries an address");
  a_uae_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == `SFCAF_REG_UAE
    |-> avs_readdata_o[31:1] == 31'h0)
    else $error("extension upper bits not zero");

  c_exec: cover property (exec_valid_o);
  c_drive: cover property (io_oe_o == 4'h2);
  c_ack: cover property ($fell(avs_waitrequest_o));
endmodule // sfcaf_frontend_sva

bind sfcaf_frontend sfcaf_frontend_sva #(.AW(AW)) u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .io_o(io_o), .io_oe_o(io_oe_o),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .exec_valid_o(exec_valid_o),
  .exec_op_o(exec_op_o), .exec_addr_o(exec_addr_o));
`default_nettype wire

// file: tb/sfcaf_host.sv
// host serial master model: chip select, serial clock and data lines
// assumes the bench calls its tasks; each change lands by nba at a clk_i rise
`default_nettype none

module sfcaf_host (
  input  wire logic       clk_i,  // system clock
  input  wire logic [3:0] io_i,   // resolved data lines
  output var  logic       cs_n_o, // chip select, active low
  output var  logic       sclk_o, // serial clock
  output var  logic [3:0] io_o    // host data drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_hi = 1'b0;
  logic quad = 1'b0;

  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h0;
  end

  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic start();
    sclk_o <= idle_hi;
    half();
    cs_n_o <= 1'b0;
    half();
  endtask

  // n clocks: single line msb first, or nibbles in quad
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      sclk_o <= 1'b0;
      io_o <= quad ? ((i == 0) ? b[7:4] : b[3:0]) : {3'h0, b[7 - i]};
      half();
      sclk_o <= 1'b1;
      half();
    end
  endtask

  task automatic get(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      sclk_o <= 1'b0;
      io_o <= ~io_o;
      half();
      sclk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      b = {b[6:0], io_i[1]};
      repeat (2) @(posedge clk_i);
    end
  endtask

  task automatic stop();
    sclk_o <= idle_hi;
    half();
    cs_n_o <= 1'b1;
    io_o <= ~io_o;
    half();
    half();
  endtask
endmodule // sfcaf_host
`default_nettype wire

// file: tb/serial_flash_cmd_address_frontend_tb.sv
// testbench for the serial flash front end: avalon register access and host frames
// assumes the host model and the bound checker are compiled alongside
`default_nettype none
`include "sfcaf_consts.vh"

module serial_flash_cmd_address_frontend_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o, r;
  logic        avs_waitrequest_o, exec_valid_o, cs_n, sclk;
  logic [7:0]  exec_op_o, ex_op, b;
  logic [24:0] exec_addr_o, ex_ad;
  logic [3:0]  io_o, io_oe_o, host_io, io_line;
  int          err_total = 0, total_checks = 0, cyc = 0, ex_n = 0;
  logic [7:0]  ops [6] = '{`SFCAF_OP_PP, `SFCAF_OP_SE, `SFCAF_OP_BE32K, `SFCAF_OP_BE, `SFCAF_OP_CE1, `SFCAF_OP_CE2};

  always #50 clk_i = ~clk_i;
  assign io_line = (io_oe_o & io_o) | (~io_oe_o & host_io);

  sfcaf_frontend dut (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_line), .io_o(io_o),
    .io_oe_o(io_oe_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .exec_valid_o(exec_valid_o), .exec_op_o(exec_op_o),
    .exec_addr_o(exec_addr_o));
  sfcaf_host host (.clk_i(clk_i), .io_i(io_line), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(host_io));

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (exec_valid_o === 1'b1)
    begin
      ex_n <= ex_n + 1;
      ex_op <= exec_op_o;
      ex_ad <= exec_addr_o;
    end
    if (cyc == 40000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held up to the rise that sees waitrequest low; data taken and request released there
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task automatic snd(input logic [7:0] v);
    host.put(v, host.quad ? 2 : 8);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd);
    host.start();
    snd(op);
    for (int i = na - 1; i >= 0; i--) snd(a[8*i +: 8]);
    repeat (nd) snd(8'h3C);
    host.stop();
  endtask

  task automatic exq(input int n, input logic [7:0] op, input logic [24:0] ad);
    chk(ex_n, n);
    chk(ex_op, op);
    chk(ex_ad, ad);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(`SFCAF_REG_CONFIG, 32'h0);
    rdc(`SFCAF_REG_UAE, 32'h0);
    rdc(`SFCAF_REG_RDATA, 32'hFF);
    rdc(5'h1C, 32'h0);
    acc(1'b1, `SFCAF_REG_UAE, 32'hFF);
    rdc(`SFCAF_REG_UAE, 32'h1);
    avs_byteenable_i <= 4'hE;
    acc(1'b1, `SFCAF_REG_UAE, 32'h0);
    avs_byteenable_i <= 4'hF;
    rdc(`SFCAF_REG_UAE, 32'h1);
    acc(1'b1, `SFCAF_REG_RDATA, 32'hA5);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      cmd(ops[i], 32'h123456, (i < 4) ? 3 : 0, (i == 0) ? 1 : 0);
      exq(i + 1, ops[i], (i < 4) ? 25'h1123456 : 25'h0);
    end
    rdc(`SFCAF_REG_EVENTS, 32'h4);
    $display("test segment commands done");
    cmd(`SFCAF_OP_ENWIDE, 32'h0, 0, 0);
    rdc(`SFCAF_REG_CONFIG, 32'h1);
    cmd(`SFCAF_OP_SE, 32'h00ABCDEF, 4, 0);
    exq(7, `SFCAF_OP_SE, 25'h0ABCDEF);
    cmd(`SFCAF_OP_EXWIDE, 32'h0, 0, 0);
    rdc(`SFCAF_REG_CONFIG, 32'h0);
    cmd(`SFCAF_OP_SE4B, 32'h01000010, 4, 0);
    exq(8, `SFCAF_OP_SE4B, 25'h1000010);
    $display("test wide address done");
    acc(1'b1, `SFCAF_REG_EVENTS, 32'h7);
    host.start();
    snd(`SFCAF_OP_SE);
    repeat (3) snd(8'h00);
    host.put(8'h00, 3);
    host.stop();
    chk(ex_n, 8);
    host.start();
    host.put(`SFCAF_OP_ENWIDE, 5);
    host.stop();
    rdc(`SFCAF_REG_CONFIG, 32'h0);
    rdc(`SFCAF_REG_EVENTS, 32'h1);
    rdc(`SFCAF_REG_LASTCMD, 32'h21);
    $display("test byte boundary done");
    acc(1'b1, `SFCAF_REG_EVENTS, 32'h7);
    host.idle_hi = 1'b1;
    host.start();
    snd(`SFCAF_OP_READ);
    repeat (3) snd(8'hFF);
    rdc(`SFCAF_REG_CONFIG, 32'h4);
    repeat (2)
    begin
      host.get(b);
      chk(b, 8'hA5);
    end
    host.put(8'h00, 3);
    host.stop();
    host.idle_hi = 1'b0;
    rdc(`SFCAF_REG_UAE, 32'h1);
    rdc(`SFCAF_REG_EVENTS, 32'h0);
    rdc(`SFCAF_REG_ADDR, 32'h1);
    host.start();
    snd(`SFCAF_OP_FAST);
    repeat (4) snd(8'h00);
    host.get(b);
    host.stop();
    chk(b, 8'hA5);
    rdc(`SFCAF_REG_ADDR, 32'h1000001);
    $display("test mode three read done");
    host.start();
    snd(8'hFF);
    rdc(`SFCAF_REG_CONFIG, 32'h0);
    host.get(b);
    chk(io_oe_o, 4'h0);
    host.stop();
    $display("test unknown opcode done");
    acc(1'b1, `SFCAF_REG_BUSY, 32'h1);
    cmd(`SFCAF_OP_PP, 32'h000100, 3, 1);
    chk(ex_n, 8);
    rdc(`SFCAF_REG_EVENTS, 32'h2);
    host.start();
    snd(`SFCAF_OP_RDSR);
    host.get(b);
    host.stop();
    chk(b, 8'h01);
    acc(1'b1, `SFCAF_REG_BUSY, 32'h0);
    $display("test busy done");
    cmd(`SFCAF_OP_QENTER, 32'h0, 0, 0);
    rdc(`SFCAF_REG_CONFIG, 32'h2);
    host.quad = 1'b1;
    cmd(`SFCAF_OP_QEXIT, 32'h0, 0, 0);
    host.quad = 1'b0;
    rdc(`SFCAF_REG_CONFIG, 32'h0);
    cmd(`SFCAF_OP_WRUAE, 32'h0, 0, 1);
    rdc(`SFCAF_REG_UAE, 32'h0);
    host.start();
    snd(`SFCAF_OP_RDUAE);
    host.get(b);
    host.stop();
    chk(b, 8'h00);
    $display("test quad protocol done");
    report_and_stop();
  end
endmodule // serial_flash_cmd_address_frontend_tb
`default_nettype wire
